// ### core/cmp_vref_ctrl.sv
/*
 * comparator and ladder reference control with AXI4-Lite registers.
 * assumes raw comparator results arrive asynchronous from the analog cores,
 * and that the pad logic obeys the override and analog-force outputs.
 */
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cmp_vref_ctrl (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi write address
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    // axi write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    // axi write response
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi read address
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    // axi read data
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // raw comparator results from the analog cores
    input  wire logic [1:0]  cmp_raw_result,
    // analog controls
    output var  logic [1:0]  cmp_enable,
    output var  logic        second_cmp_neg_select,
    output var  logic [2:0]  second_cmp_pos_route,
    output var  logic        ladder_power_enable,
    output var  logic        ladder_range_low,
    output var  logic [3:0]  ladder_level_code,
    output var  logic        ladder_ground,
    // pin overrides
    output var  logic [2:0]  pin_force_analog,
    output var  logic        first_cmp_out_pin,
    output var  logic        first_cmp_out_oe,
    output var  logic        second_cmp_out_pin,
    output var  logic        second_cmp_out_oe,
    output var  logic [1:0]  ladder_pin_drive,
    // wake flag
    output var  logic        cmp_wake_flag
);
    // ==========================================================
    // state
    typedef enum logic [2:0] {
        wr_idle = 3'h1,
        wr_resp = 3'h2,
        wr_hold = 3'h4
    } wr_state_e;

    typedef struct packed {
        logic [1:0]  sync_a;
        logic [1:0]  sync_b;
        logic [1:0]  latched;
        logic        wake;
        logic [6:0]  ctrl1;
        logic [6:0]  ctrl2;
        logic [7:0]  vref;
        wr_state_e   wst;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [1:0]  cen;
        logic        nsel;
        logic [2:0]  proute;
        logic [2:0]  fanalog;
        logic [1:0]  outpin;
        logic [1:0]  outoe;
        logic        lpow;
        logic        lrng;
        logic [3:0]  lcode;
        logic        lgnd;
        logic [1:0]  lpin;
    } state_s;

    state_s st;
    state_s next_st;

    // reported result after polarity
    function automatic logic polar(input logic raw, input logic [6:0] c);
        polar = c[cmp_vref_pkg::polarity_bit] ? raw : ~raw;
    endfunction : polar

    // register word as seen by a read
    function automatic logic [7:0] ctrl_word(input logic res, input logic [6:0] c);
        ctrl_word = {res, c};
    endfunction : ctrl_word

    logic [1:0] res;
    logic [1:0] wake_en;
    logic       wr_go;
    logic       rd_go;
    logic       do_clear;
    logic [3:0] waddr;
    logic [3:0] raddr;
    logic       c2_on;
    logic [2:0] sel2;

    // ==========================================================
    // next-state logic
    always_comb begin
        next_st = st;
        // two-stage synchroniser
        next_st.sync_a = cmp_raw_result;
        next_st.sync_b = st.sync_a;
        res[0] = polar(st.sync_b[0], st.ctrl1);
        res[1] = polar(st.sync_b[1], st.ctrl2);
        wake_en = {~st.ctrl2[cmp_vref_pkg::wake_dis_bit], ~st.ctrl1[cmp_vref_pkg::wake_dis_bit]};
        waddr = s_axi_awaddr[cmp_vref_pkg::addr_w-1:0];
        raddr = s_axi_araddr[cmp_vref_pkg::addr_w-1:0];
        do_clear = 1'b0;

        // write channel: address and data must be taken on the same edge to write
        if (s_axi_awvalid && st.awready) begin
            next_st.awready = 1'b0;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.wready = 1'b0;
        end
        wr_go = (s_axi_awvalid && st.awready && s_axi_wvalid && st.wready);
        unique case (st.wst)
            wr_idle: begin
                if (wr_go) begin
                    next_st.bvalid = 1'b1;
                    next_st.bresp = cmp_vref_pkg::resp_okay;
                    next_st.wst = wr_resp;
                    if (s_axi_wstrb[0]) begin
                        unique case (waddr)
                            cmp_vref_pkg::cmp1_ctrl_addr: next_st.ctrl1 = s_axi_wdata[6:0];
                            cmp_vref_pkg::cmp2_ctrl_addr: next_st.ctrl2 = s_axi_wdata[6:0];
                            cmp_vref_pkg::vref_ctrl_addr: next_st.vref = s_axi_wdata[7:0];
                            cmp_vref_pkg::wake_stat_addr: do_clear = ~s_axi_wdata[0];
                            default: next_st.bresp = cmp_vref_pkg::resp_slverr;
                        endcase
                    end else if (waddr > cmp_vref_pkg::wake_stat_addr || waddr[1:0] != 2'h0) begin
                        next_st.bresp = cmp_vref_pkg::resp_slverr;
                    end
                end else if (!st.awready && !st.wready) begin
                    next_st.wst = wr_hold;
                end
            end
            wr_hold: begin
                // one of the two items taken, waiting for its partner
                if (st.awready && !st.wready && s_axi_awvalid) begin
                    next_st.awready = 1'b0;
                end
                if (!next_st.awready && !next_st.wready) begin
                    next_st.wst = wr_idle;
                end
            end
            wr_resp: begin
                if (s_axi_bready) begin
                    next_st.bvalid = 1'b0;
                    next_st.awready = 1'b1;
                    next_st.wready = 1'b1;
                    next_st.wst = wr_idle;
                end
            end
            default: next_st.wst = wr_idle;
        endcase
        // partial handshake: address and data taken on different edges
        if (st.wst != wr_resp && !next_st.awready && !next_st.wready && !wr_go) begin
            next_st.bvalid = 1'b1;
            next_st.bresp = cmp_vref_pkg::resp_slverr;
            next_st.wst = wr_resp;
        end

        // read channel
        rd_go = s_axi_arvalid && st.arready;
        if (rd_go) begin
            next_st.arready = 1'b0;
            next_st.rvalid = 1'b1;
            next_st.rresp = cmp_vref_pkg::resp_okay;
            unique case (raddr)
                cmp_vref_pkg::cmp1_ctrl_addr: next_st.rdata = {24'h0, ctrl_word(res[0], st.ctrl1)};
                cmp_vref_pkg::cmp2_ctrl_addr: next_st.rdata = {24'h0, ctrl_word(res[1], st.ctrl2)};
                cmp_vref_pkg::vref_ctrl_addr: next_st.rdata = {24'h0, st.vref};
                cmp_vref_pkg::wake_stat_addr: next_st.rdata = {31'h0, st.wake};
                default: begin
                    next_st.rdata = 32'h0;
                    next_st.rresp = cmp_vref_pkg::resp_slverr;
                end
            endcase
            // reading either control register latches the synchronised results for change detection
            if (raddr == cmp_vref_pkg::cmp1_ctrl_addr || raddr == cmp_vref_pkg::cmp2_ctrl_addr) begin
                next_st.latched = st.sync_b;
            end
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
            next_st.arready = 1'b1;
        end

        // wake flag: set wins over clear, held until cleared
        if (do_clear) begin
            next_st.wake = 1'b0;
        end
        if (|(wake_en & (st.sync_b ^ st.latched))) begin
            next_st.wake = 1'b1;
        end

        // comparator enables and input routing
        next_st.cen = {st.ctrl2[cmp_vref_pkg::enable_bit], st.ctrl1[cmp_vref_pkg::enable_bit]};
        c2_on = st.ctrl2[cmp_vref_pkg::enable_bit];
        next_st.nsel = st.ctrl2[cmp_vref_pkg::neg_sel_bit];
        sel2 = 3'h0;
        if (st.ctrl2[cmp_vref_pkg::pos_sel_a_bit]) begin
            sel2[cmp_vref_pkg::pin_second_pos] = 1'b1;
        end else if (st.ctrl2[cmp_vref_pkg::pos_sel_b_bit]) begin
            sel2[cmp_vref_pkg::pin_first_pos] = 1'b1;
        end else begin
            sel2[cmp_vref_pkg::pin_second_neg] = 1'b1;
        end
        next_st.proute = sel2;
        if (st.ctrl2[cmp_vref_pkg::neg_sel_bit]) begin
            sel2[cmp_vref_pkg::pin_second_neg] = 1'b1;
        end
        // force selected pins analog while on, stored pad settings untouched
        next_st.fanalog = c2_on ? sel2 : 3'h0;
        if (st.ctrl1[cmp_vref_pkg::enable_bit]) begin
            next_st.fanalog[cmp_vref_pkg::pin_first_pos] = 1'b1;
        end

        // output pin routing
        next_st.outpin = res;
        next_st.outoe[0] = ~st.ctrl1[cmp_vref_pkg::pin_drive_n];
        next_st.outoe[1] = ~st.ctrl2[cmp_vref_pkg::pin_drive_n] & c2_on;

        // ladder controls
        next_st.lpow = st.vref[cmp_vref_pkg::ladder_en_bit];
        next_st.lrng = st.vref[cmp_vref_pkg::ladder_rng_bit];
        next_st.lcode = st.vref[cmp_vref_pkg::ladder_code_w-1:0];
        next_st.lgnd = ~st.vref[cmp_vref_pkg::ladder_en_bit] & st.vref[cmp_vref_pkg::ladder_rng_bit]
                       & (st.vref[cmp_vref_pkg::ladder_code_w-1:0] == 4'h0);
        next_st.lpin = {st.vref[cmp_vref_pkg::ladder_pin2_bit], st.vref[cmp_vref_pkg::ladder_pin1_bit]};
    end

    // ==========================================================
    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.ctrl1 <= cmp_vref_pkg::cmp_ctrl_reset;
            st.ctrl2 <= cmp_vref_pkg::cmp_ctrl_reset;
            st.vref <= cmp_vref_pkg::vref_ctrl_reset;
            st.wst <= wr_idle;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // outputs
    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign cmp_enable = st.cen;
    assign second_cmp_neg_select = st.nsel;
    assign second_cmp_pos_route = st.proute;
    assign ladder_power_enable = st.lpow;
    assign ladder_range_low = st.lrng;
    assign ladder_level_code = st.lcode;
    assign ladder_ground = st.lgnd;
    assign pin_force_analog = st.fanalog;
    assign first_cmp_out_pin = st.outpin[0];
    assign first_cmp_out_oe = st.outoe[0];
    assign second_cmp_out_pin = st.outpin[1];
    assign second_cmp_out_oe = st.outoe[1];
    assign ladder_pin_drive = st.lpin;
    assign cmp_wake_flag = st.wake;

    // ==========================================================
    // assertions
    sequence s_cmp1_read;
        s_axi_arvalid && s_axi_arready && s_axi_araddr[3:0] == cmp_vref_pkg::cmp1_ctrl_addr;
    endsequence

    a_result_sync: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |-> st.sync_b == $past(cmp_raw_result, 2))
        else $error("result not delayed by two stages");
    a_read_latch: assert property (@(posedge aclk) disable iff (!aresetn)
        s_cmp1_read |=> st.latched == $past(st.sync_b))
        else $error("read did not latch outputs");
    a_wake_set: assert property (@(posedge aclk) disable iff (!aresetn)
        (!st.ctrl1[0] && st.sync_b[0] != st.latched[0]) |=> cmp_wake_flag)
        else $error("wake flag missed a change");
    a_wake_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (cmp_wake_flag && !(s_axi_wvalid && s_axi_awvalid)) |=> cmp_wake_flag)
        else $error("wake flag dropped without clear");
    a_result_read: assert property (@(posedge aclk) disable iff (!aresetn)
        s_cmp1_read |=> s_axi_rdata[cmp_vref_pkg::result_bit] ==
            ($past(st.ctrl1[cmp_vref_pkg::polarity_bit]) ? $past(st.sync_b[0]) : ~$past(st.sync_b[0])))
        else $error("result bit misreported");
    a_pin_drive: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> first_cmp_out_oe == !$past(st.ctrl1[6]))
        else $error("pin drive wrong");
    a_ladder_gnd: assert property (@(posedge aclk) disable iff (!aresetn)
        (st.vref == 8'h10) |=> ladder_ground)
        else $error("ladder ground missing");
    a_second_off: assert property (@(posedge aclk) disable iff (!aresetn)
        !st.ctrl2[3] && !st.ctrl1[3] |=> pin_force_analog == 3'h0)
        else $error("pins forced while off");
endmodule : cmp_vref_ctrl
`default_nettype wire

// ### core/cmp_vref_pkg.sv
/*
 * constants for the comparator and ladder reference control block:
 * register offsets, bit positions, reset values and pin map.
 * assumes an AXI4-Lite slave with 32-bit data and one word per register.
 */
package cmp_vref_pkg;
    // ==========================================================
    // register map (byte addresses)
    localparam logic [3:0] cmp1_ctrl_addr  = 4'h0;
    localparam logic [3:0] cmp2_ctrl_addr  = 4'h4;
    localparam logic [3:0] vref_ctrl_addr  = 4'h8;
    localparam logic [3:0] wake_stat_addr  = 4'hc;
    localparam int         addr_w          = 4;

    // ==========================================================
    // comparator control fields
    localparam int result_bit    = 7;
    localparam int pin_drive_n   = 6;
    localparam int polarity_bit  = 5;
    localparam int pos_sel_b_bit = 4;
    localparam int enable_bit    = 3;
    localparam int neg_sel_bit   = 2;
    localparam int pos_sel_a_bit = 1;
    localparam int wake_dis_bit  = 0;
    localparam logic [6:0] cmp_ctrl_reset = 7'h7f;

    // ==========================================================
    // reference control fields
    localparam int ladder_en_bit   = 7;
    localparam int ladder_pin1_bit = 6;
    localparam int ladder_pin2_bit = 5;
    localparam int ladder_rng_bit  = 4;
    localparam int ladder_code_w   = 4;
    localparam logic [7:0] vref_ctrl_reset = 8'h1f;

    // ==========================================================
    // analog pin map for selection and override outputs
    localparam int pin_first_pos  = 0;
    localparam int pin_second_pos = 1;
    localparam int pin_second_neg = 2;
    localparam int pin_count      = 3;

    // axi response codes
    localparam logic [1:0] resp_okay   = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
endpackage : cmp_vref_pkg

// ### sim/cmp_analog_model.sv
/*
 * model of the analog comparator cores and the ladder reference.
 * assumes pin voltages in units where the supply is 3072.
 */
`timescale 1ns/1ps
`default_nettype none
module cmp_analog_model (
    // pin voltages
    input  wire logic [11:0] v_first_pos,
    input  wire logic [11:0] v_first_neg,
    input  wire logic [11:0] v_second_pos,
    input  wire logic [11:0] v_second_neg,
    // controls from the block
    input  wire logic [1:0]  cmp_enable,
    input  wire logic        second_cmp_neg_select,
    input  wire logic [2:0]  second_cmp_pos_route,
    input  wire logic        ladder_power_enable,
    input  wire logic        ladder_range_low,
    input  wire logic [3:0]  ladder_level_code,
    input  wire logic        ladder_ground,
    // raw results
    output var  logic [1:0]  cmp_raw_result
);
    logic [11:0] ladder;
    logic [11:0] pos2;
    logic [11:0] neg2;

    // ==========================================================
    // ladder tap, input muxes and decisions
    always_comb begin
        ladder = ladder_range_low ? 12'(ladder_level_code * 128) : 12'(768 + ladder_level_code * 96);
        if (ladder_ground) begin
            ladder = 12'h000;
        end else if (!ladder_power_enable) begin
            ladder = 12'hfff;
        end
        pos2 = second_cmp_pos_route[0] ? v_first_pos : (second_cmp_pos_route[1] ? v_second_pos : v_second_neg);
        neg2 = second_cmp_neg_select ? v_second_neg : ladder;
        cmp_raw_result[0] = cmp_enable[0] && (v_first_pos > v_first_neg);
        cmp_raw_result[1] = cmp_enable[1] && (pos2 > neg2);
    end
endmodule : cmp_analog_model
`default_nettype wire

// ### sim/comparator_and_vref_control_tb_top.sv
/*
 * self-checking bench for the comparator and reference control block.
 * assumes the analog model in cmp_analog_model and a 200 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module comparator_and_vref_control_tb_top;
    localparam logic [1:0] ok  = cmp_vref_pkg::resp_okay;
    localparam logic [1:0] err = cmp_vref_pkg::resp_slverr;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, seed = 32'h36c09ec3;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, sneg, lpow, lrng, lgnd, o1, oe1, o2, oe2, wake;
    logic [1:0]  bresp, rresp, raw, cen, lpin;
    logic [2:0]  route, fan, b, er;
    logic [3:0]  lcode, wstrb = 4'hf;
    logic [7:0]  c, v;
    logic [11:0] v1p = 12'd2000, v1n = 12'd1000, v2p = 12'd500, v2n = 12'd1500, pos, neg;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    int          bad_count = 0;
    int          total_checks = 0;

    // ==========================================================
    // clock, design and far side
    always #2.5 aclk = ~aclk;

    cmp_vref_ctrl i_cmp_vref_ctrl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmp_raw_result(raw),
        .cmp_enable(cen), .second_cmp_neg_select(sneg), .second_cmp_pos_route(route), .ladder_power_enable(lpow),
        .ladder_range_low(lrng), .ladder_level_code(lcode), .ladder_ground(lgnd), .pin_force_analog(fan),
        .first_cmp_out_pin(o1), .first_cmp_out_oe(oe1), .second_cmp_out_pin(o2), .second_cmp_out_oe(oe2),
        .ladder_pin_drive(lpin), .cmp_wake_flag(wake));

    cmp_analog_model i_cmp_analog_model (.v_first_pos(v1p), .v_first_neg(v1n), .v_second_pos(v2p),
        .v_second_neg(v2n), .cmp_enable(cen), .second_cmp_neg_select(sneg), .second_cmp_pos_route(route),
        .ladder_power_enable(lpow), .ladder_range_low(lrng), .ladder_level_code(lcode), .ladder_ground(lgnd),
        .cmp_raw_result(raw));

    // ==========================================================
    // checking and reporting
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // response watcher takes the oldest note per response
    always @(posedge aclk) begin
        if (rvalid && rready)
            chk({rresp, rdata}, rq.pop_front());
        if (bvalid && bready)
            chk({32'h0, bresp}, {32'h0, bq.pop_front()});
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    // ==========================================================
    // bus master tasks
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        n = 0;
        bq.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready) && n < 100);
        bready <= 1'b0;
        if (!(bvalid && bready)) begin
            bad_count++;
            results();
        end
        @(posedge aclk); // one idle edge between transfers
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [33:0] e);
        int n;
        n = 0;
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready) && n < 100);
        rready <= 1'b0;
        if (!(rvalid && rready)) begin
            bad_count++;
            results();
        end
        @(posedge aclk); // one idle edge between transfers
    endtask : rd

    task automatic settle;
        repeat (6) @(posedge aclk);
    endtask : settle

    // ==========================================================
    // main sequence
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        settle();
        rd(32'h0, {ok, 32'hff});
        rd(32'h4, {ok, 32'h7f});
        rd(32'h8, {ok, 32'h1f});
        chk({cen, fan, oe1, oe2, lgnd}, {2'b11, 3'b111, 3'b000});
        $display("test reset done");
        wr(32'h0, 32'h88, ok);
        settle();
        rd(32'h0, {ok, 32'h08});
        chk({oe1, o1}, 2'b10);
        wr(32'h0, 32'h28, ok);
        settle();
        rd(32'h0, {ok, 32'ha8});
        chk({oe1, o1}, 2'b11);
        wr(32'hc, 32'h0, ok);
        settle();
        chk(wake, 1'b0);
        v1p <= 12'd500;
        settle();
        chk(wake, 1'b1);
        rd(32'hc, {ok, 32'h1});
        settle();
        rd(32'h0, {ok, 32'h28});
        wr(32'hc, 32'h0, ok);
        settle();
        chk(wake, 1'b0);
        wr(32'h0, 32'h29, ok);
        rd(32'h0, {ok, 32'h29});
        v1p <= 12'd2000;
        settle();
        chk(wake, 1'b0);
        $display("test wake done");
        wr(32'h8, 32'h85, ok);
        for (int i = 0; i < 8; i++) begin
            b = i[2:0];
            c = 8'h29 | {3'b000, b[2], 1'b0, b[1], b[0], 1'b0};
            pos = b[0] ? v2p : (b[2] ? v1p : v2n);
            neg = b[1] ? v2n : 12'd1248;
            er = b[0] ? 3'b010 : (b[2] ? 3'b001 : 3'b100);
            wr(32'h4, {24'h0, c}, ok);
            settle();
            rd(32'h4, {ok, 24'h0, pos > neg, c[6:0]});
            chk(route, er);
            chk(sneg, b[1]);
            chk(fan, 3'b001 | er | {b[1], 2'b00});
            chk({oe2, o2}, {1'b1, pos > neg});
        end
        wr(32'h4, 32'h21, ok);
        settle();
        chk({cen, fan, oe2}, {2'b01, 3'b001, 1'b0});
        $display("test routing done");
        for (int i = 0; i < 9; i++) begin
            seed = xs(seed);
            v = (i == 0) ? 8'h10 : seed[7:0];
            wr(32'h8, {24'h0, v}, ok);
            settle();
            rd(32'h8, {ok, 24'h0, v});
            chk({lpow, lpin, lrng, lcode}, {v[7], v[5], v[6], v[4:0]});
            chk(lgnd, !v[7] && v[4] && v[3:0] == 4'h0);
        end
        wstrb <= 4'he;
        wr(32'h8, 32'h0, ok);
        wstrb <= 4'hf;
        rd(32'h8, {ok, 24'h0, v});
        rd(32'h3, {err, 32'h0});
        wr(32'h6, 32'h0, err);
        $display("test reference done");
        results();
    end
endmodule : comparator_and_vref_control_tb_top
`default_nettype wire
